// >>> common/smsp_pkg.sv
/*
 * shared constants and carrier types of the serial master/slave port.
 * assumes a 32-bit apb slave interface with byte addresses on 8 bits.
 */
package smsp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CONTROL = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_DATA    = 8'h08;
  localparam logic [7:0]  OFF_PINDIR  = 8'h0C;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_ORDER  = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLOCK_POLARITY   = 3;
  localparam int CTL_CLOCK_PHASE   = 2;
  localparam int STA_DONE   = 7;
  localparam int STA_WRITE_COLLISION_FLAG   = 6;
  localparam int STA_DBL    = 0;
  localparam int DIR_MOSI   = 0;
  localparam int DIR_SCK    = 1;
  localparam int DIR_MISO   = 2;
  localparam int DIR_SS     = 3;
  localparam int DIR_SS_LVL = 4;

  // ************************************************************
  // reset values and divisors
  // ************************************************************
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [4:0]  RST_PINDIR  = 5'h10;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [3:0]  RST_SYNC    = 4'h8;
  localparam logic [7:0]  DIV_R0      = 8'h04;
  localparam logic [7:0]  DIV_R1      = 8'h10;
  localparam logic [7:0]  DIV_R2      = 8'h40;
  localparam logic [7:0]  DIV_R3      = 8'h80;
  localparam logic [3:0]  LAST_EDGE   = 4'hF;
  localparam logic [2:0]  LAST_BIT    = 3'h7;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic ss_n;
    logic miso;
    logic mosi;
    logic sck;
  } smsp_pin_in_t;

  typedef struct packed {
    logic ss_o;
    logic ss_oe;
    logic miso_o;
    logic miso_oe;
    logic mosi_o;
    logic mosi_oe;
    logic sck_o;
    logic sck_oe;
  } smsp_pin_out_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        done_f;
    logic        write_collision_flag_f;
    logic        dbl;
    logic [4:0]  pdir;
    logic [7:0]  sh;
    logic [7:0]  rx;
    logic [7:0]  txb;
    logic        dout;
    logic        busy;
    logic        tog;
    logic [3:0]  ecnt;
    logic [2:0]  bcnt;
    logic [6:0]  mcnt;
    logic        sck_d;
    logic        arm_f;
    logic        arm_w;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } smsp_state_t;

endpackage

// >>> core/smsp_port.sv
/*
 * byte-wide serial master/slave port with apb register access.
 * assumes an apb master on pclk and an external tristate resolver.
 */
// Operation
// - slave: select low activates, miso drives if set
// - slave, select high: passive, nothing received
// - select rising resets counter, drops partial bits
// - master, select output: plain general output
// - master, select input low: demote to slave
// - demotion also sets transfer-done flag
// - interrupt needs enable, flag, global enable
// - nothing happens unless port enabled, save select pin drive per its direction bit
// - bit order one: lsb first, else msb
// - polarity sets idle sck level
// - phase picks sample and setup edges
// - master sck divisors with double rate
// - flag set after every completed byte
// - flag cleared by vector or status-data
// - data write while busy sets collision
// - status bits five to one read zero
// - double rate doubles only master sck
// - data write starts, read gives buffer
// - opposite edges, modes zero to three
// - single transmit, double receive buffer
// - master shifts eight bits then stops
`timescale 1ns/1ps
module smsp_port (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [smsp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire smsp_pkg::smsp_pin_in_t       pins_in,
  output smsp_pkg::smsp_pin_out_t           pins_out,
  input  wire logic                         cpu_global_irq_en,
  input  wire logic                         irq_vector_ack,
  output logic                              xfer_irq
);

  smsp_pkg::smsp_state_t s_r;
  smsp_pkg::smsp_state_t s_nxt;
  logic [3:0]            syn;
  logic                  sck_s;
  logic                  mosi_s;
  logic                  miso_s;
  logic                  ss_s;
  logic                  en;
  logic                  mst;
  logic                  clock_polarity;
  logic                  clock_phase;
  logic                  lsb;
  logic                  slv_on;
  logic                  busy_any;
  logic [6:0]            half;
  logic                  in_bit;
  logic                  obit;
  logic [7:0]            shifted;
  logic                  acc;
  logic                  data_acc;
  logic                  data_wr;
  logic                  done_ev;
  logic                  demote;
  logic                  write_collision_flag_ev;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  smsp_sync3 #(
    .W       (4),
    .RST_VAL (smsp_pkg::RST_SYNC)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (pins_in),
    .q_out   (syn)
  );

  assign sck_s  = syn[0];
  assign mosi_s = syn[1];
  assign miso_s = syn[2];
  assign ss_s   = syn[3];

  // ************************************************************
  // decoded control
  // ************************************************************
  assign en       = s_r.ctrl[smsp_pkg::CTL_ENABLE];
  assign mst      = s_r.ctrl[smsp_pkg::CTL_MASTER];
  assign clock_polarity     = s_r.ctrl[smsp_pkg::CTL_CLOCK_POLARITY];
  assign clock_phase     = s_r.ctrl[smsp_pkg::CTL_CLOCK_PHASE];
  assign lsb      = s_r.ctrl[smsp_pkg::CTL_ORDER];
  assign slv_on   = en && !mst;
  assign busy_any = s_r.busy || (s_r.bcnt != 3'h0);
  assign in_bit   = mst ? miso_s : mosi_s;
  assign obit     = lsb ? s_r.sh[0] : s_r.sh[7];
  assign shifted  = lsb ? {in_bit, s_r.sh[7:1]} : {s_r.sh[6:0], in_bit};
  assign acc      = psel && penable && s_r.pready;
  assign data_acc = acc && (paddr == smsp_pkg::OFF_DATA);
  assign data_wr  = data_acc && pwrite;

  // half sck period in pclk cycles
  function automatic logic [6:0] half_of(input logic dbl, input logic [1:0] r);
    logic [7:0] d;
    case (r)
      2'h0:    d = smsp_pkg::DIV_R0;
      2'h1:    d = smsp_pkg::DIV_R1;
      2'h2:    d = smsp_pkg::DIV_R2;
      default: d = smsp_pkg::DIV_R3;
    endcase
    if (dbl) begin
      d = d >> 1;
    end
    return d[7:1];
  endfunction

  assign half = half_of(s_r.dbl, s_r.ctrl[1:0]);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt   = s_r;
    done_ev = 1'b0;
    demote  = 1'b0;
    write_collision_flag_ev = 1'b0;
    s_nxt.sck_d = sck_s;

    // master clock generator
    if (en && mst && s_r.busy) begin
      if (s_r.mcnt == 7'h00) begin
        s_nxt.mcnt = half - 7'h01;
        s_nxt.tog  = ~s_r.tog;
        s_nxt.ecnt = s_r.ecnt + 4'h1;
        if (s_r.ecnt[0] == clock_phase) begin
          s_nxt.sh = shifted;
        end else begin
          s_nxt.dout = obit;
        end
        if (s_r.ecnt == smsp_pkg::LAST_EDGE) begin
          s_nxt.busy = 1'b0;
          s_nxt.rx   = s_nxt.sh;
          done_ev    = 1'b1;
        end
      end else begin
        s_nxt.mcnt = s_r.mcnt - 7'h01;
      end
    end

    // slave engine, gated by select
    if (slv_on && !ss_s) begin
      if (sck_s != s_r.sck_d) begin
        if ((sck_s != clock_polarity) != clock_phase) begin
          s_nxt.sh   = shifted;
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          if (s_r.bcnt == smsp_pkg::LAST_BIT) begin
            s_nxt.rx = shifted;
            done_ev  = 1'b1;
          end
        end else begin
          s_nxt.dout = obit;
        end
      end
    end else if (slv_on) begin
      s_nxt.bcnt = 3'h0;
      if (s_r.bcnt != 3'h0) begin
        s_nxt.sh = s_r.txb;
      end
      s_nxt.dout = lsb ? s_r.txb[0] : s_r.txb[7];
    end

    // select pulled low while master with select as input
    if (en && mst && !s_r.pdir[smsp_pkg::DIR_SS] && !ss_s) begin
      s_nxt.ctrl[smsp_pkg::CTL_MASTER] = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.tog  = 1'b0;
      demote     = 1'b1;
    end

    if (!en) begin
      s_nxt.busy = 1'b0;
      s_nxt.bcnt = 3'h0;
      s_nxt.tog  = 1'b0;
    end

    // apb: registered answer one cycle after setup
    s_nxt.pready  = psel && !penable;
    s_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      s_nxt.prdata = 32'h0000_0000;
      if (paddr == smsp_pkg::OFF_CONTROL) begin
        s_nxt.prdata[7:0] = s_r.ctrl;
      end else if (paddr == smsp_pkg::OFF_STATUS) begin
        s_nxt.prdata[7:0] = {s_r.done_f, s_r.write_collision_flag_f, 5'h00, s_r.dbl};
      end else if (paddr == smsp_pkg::OFF_DATA) begin
        s_nxt.prdata[7:0] = s_r.rx;
      end else if (paddr == smsp_pkg::OFF_PINDIR) begin
        s_nxt.prdata[4:0] = s_r.pdir;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end

    if (acc && pwrite) begin
      if (paddr == smsp_pkg::OFF_CONTROL) begin
        s_nxt.ctrl = pwdata[7:0];
      end else if (paddr == smsp_pkg::OFF_STATUS) begin
        s_nxt.dbl = pwdata[smsp_pkg::STA_DBL];
      end else if (paddr == smsp_pkg::OFF_PINDIR) begin
        s_nxt.pdir = pwdata[4:0];
      end
    end

    if (data_wr) begin
      if (busy_any) begin
        write_collision_flag_ev = 1'b1;
      end else begin
        s_nxt.sh  = pwdata[7:0];
        s_nxt.txb = pwdata[7:0];
        if (!clock_phase) begin
          s_nxt.dout = lsb ? pwdata[0] : pwdata[7];
        end
        if (en && s_nxt.ctrl[smsp_pkg::CTL_MASTER]) begin
          s_nxt.busy = 1'b1;
          s_nxt.ecnt = 4'h0;
          s_nxt.tog  = 1'b0;
          s_nxt.mcnt = half - 7'h01;
        end
      end
    end

    // flags: set wins over clear
    if (acc && !pwrite && (paddr == smsp_pkg::OFF_STATUS)) begin
      s_nxt.arm_f = s_r.prdata[smsp_pkg::STA_DONE];
      s_nxt.arm_w = s_r.prdata[smsp_pkg::STA_WRITE_COLLISION_FLAG];
    end else if (data_acc) begin
      s_nxt.arm_f = 1'b0;
      s_nxt.arm_w = 1'b0;
    end
    s_nxt.done_f = done_ev || demote || (s_r.done_f && !irq_vector_ack
                   && !(data_acc && s_r.arm_f));
    s_nxt.write_collision_flag_f = write_collision_flag_ev || (s_r.write_collision_flag_f && !(data_acc && s_r.arm_w));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{ctrl: smsp_pkg::RST_CONTROL, pdir: smsp_pkg::RST_PINDIR,
               sh: smsp_pkg::RST_BYTE, rx: smsp_pkg::RST_BYTE,
               txb: smsp_pkg::RST_BYTE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign xfer_irq = s_r.ctrl[smsp_pkg::CTL_IRQ_EN] && s_r.done_f
                    && cpu_global_irq_en;

  always_comb begin
    pins_out         = '0;
    pins_out.sck_o   = clock_polarity ^ s_r.tog;
    pins_out.mosi_o  = s_r.dout;
    pins_out.miso_o  = s_r.dout;
    pins_out.ss_o    = s_r.pdir[smsp_pkg::DIR_SS_LVL];
    pins_out.ss_oe   = !slv_on && s_r.pdir[smsp_pkg::DIR_SS];
    if (en && mst) begin
      pins_out.sck_oe  = s_r.pdir[smsp_pkg::DIR_SCK];
      pins_out.mosi_oe = s_r.pdir[smsp_pkg::DIR_MOSI];
    end else if (slv_on && !ss_s) begin
      pins_out.miso_oe = s_r.pdir[smsp_pkg::DIR_MISO];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_irq_gate: assert property (
    xfer_irq |-> (s_r.done_f && cpu_global_irq_en && s_r.ctrl[smsp_pkg::CTL_IRQ_EN]))
    else $error("interrupt raised without all enables");

  a_idle_when_off: assert property (
    !en |=> (!s_r.busy && s_r.bcnt == 3'h0))
    else $error("engine active while disabled");

  a_slave_passive: assert property (
    (slv_on && ss_s) |-> (!pins_out.miso_oe && !pins_out.mosi_oe))
    else $error("slave drives while deselected");

  a_ss_rise_reset: assert property (
    (slv_on && ss_s) |=> (s_r.bcnt == 3'h0))
    else $error("bit counter not cleared on deselect");

  a_demote_now: assert property (
    (en && mst && !s_r.pdir[smsp_pkg::DIR_SS] && !ss_s)
    |=> (!mst && !s_r.busy && s_r.done_f))
    else $error("master not demoted by select");

  a_write_collision_flag_set: assert property (
    (data_wr && busy_any) |=> (s_r.write_collision_flag_f && $stable(s_r.txb)))
    else $error("collision not flagged or data taken");

  a_sck_idle: assert property (
    (en && mst && !s_r.busy) |-> (pins_out.sck_o == clock_polarity))
    else $error("sck not at idle level");

  a_byte_length: assert property (
    ($rose(s_r.busy) && half == 7'h01) |-> s_r.busy [*8] ##1 s_r.busy [*8] ##1 !s_r.busy)
    else $error("master byte not sixteen half periods");

  a_done_ack: assert property (
    (irq_vector_ack && !done_ev && !demote) |=> !s_r.done_f)
    else $error("vector did not clear done flag");

  a_status_zero: assert property (
    ($past(psel && !penable) && $past(paddr) == smsp_pkg::OFF_STATUS)
    |-> (s_r.prdata[5:1] == 5'h00))
    else $error("reserved status bits not zero");

  c_master_byte: cover property ($fell(s_r.busy) && done_ev == 1'b0 && s_r.done_f);
  c_slave_byte: cover property (slv_on && done_ev);
  c_demotion: cover property (demote);
  c_collision: cover property (write_collision_flag_ev);

endmodule // smsp_port

// >>> core/smsp_sync3.sv
/*
 * three-stage synchroniser for pin inputs, change accepted when
 * stages two and three agree.
 * assumes inputs asynchronous to pclk.
 */
`timescale 1ns/1ps
module smsp_sync3 #(
  parameter int             W       = 4,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } smsp_sync_t;

  smsp_sync_t r_r;
  smsp_sync_t r_nxt;

  // ************************************************************
  // per-bit agreement filter
  // ************************************************************
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d_in;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.q[i] = r_r.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q_out = r_r.q;

endmodule // smsp_sync3

// >>> dv/smsp_far_slave.sv
/*
 * far-side slave model: shifts a byte out on miso, captures mosi.
 * assumes the bench loads a byte and mode while the link is idle.
 */
`timescale 1ns/1ps
module smsp_far_slave (
  input  wire logic       pclk,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [1:0] mode,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh;
  logic       sck_d;
  int         n;

  // ************************************************************
  // byte load and edge-driven shift
  // ************************************************************
  task automatic load(input logic [7:0] b);
    sh = b;
    n = 0;
    got = 8'h00;
  endtask

  assign miso = sh[7];

  always @(posedge pclk) begin
    sck_d <= sck;
    if (sck !== sck_d && n < 16) begin
      n <= n + 1;
      if (n[0] == mode[0]) begin
        got <= {got[6:0], mosi};
      end else if (n != 0) begin
        sh <= {sh[6:0], ~sh[7]};
      end
    end
  end
endmodule // smsp_far_slave

// >>> dv/smsp_port_tb.sv
/*
 * self-checking bench of the serial port: apb master, far slave model,
 * external master stimulus. assumes a 125 MHz pclk.
 */
`timescale 1ns/1ps
module smsp_port_tb;
  logic                    pclk, presetn, psel, penable, pwrite, gie, ack;
  logic [7:0]              paddr, tb, sb, got, m, ctl;
  logic [31:0]             pwdata, prdata, rd;
  logic                    pready, pslverr, err, irq, esck, emosi, ess, smiso, o;
  logic [1:0]              mode;
  logic                    sck_d;
  smsp_pkg::smsp_pin_in_t  pin;
  smsp_pkg::smsp_pin_out_t po;
  int                      num_errors, cmp_count, cyc, ne, t0, t1, h;

  assign pin.sck  = po.sck_oe ? po.sck_o : esck;
  assign pin.mosi = po.mosi_oe ? po.mosi_o : emosi;
  assign pin.miso = po.miso_oe ? po.miso_o : smiso;
  assign pin.ss_n = po.ss_oe ? po.ss_o : ess;

  smsp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pin), .pins_out(po),
    .cpu_global_irq_en(gie), .irq_vector_ack(ack), .xfer_irq(irq));

  smsp_far_slave u_far (.pclk(pclk), .sck(pin.sck), .mosi(pin.mosi), .mode(mode),
    .miso(smiso), .got(got));

  // ************************************************************
  // clock, sck edge monitor, timeout
  // ************************************************************
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sck_d <= pin.sck;
    if (pin.sck !== sck_d) begin
      ne <= ne + 1;
      if (ne == 0) t0 <= cyc;
      t1 <= cyc;
    end
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    cmp_count++;
    if (a !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask

  // pready and read data are looked at while they stand before the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(negedge pclk);
    while (pready !== 1'b1) begin
      @(negedge pclk);
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // returns two edges after the flag, so monitors have seen the last edge
  task automatic wait_irq();
    @(negedge pclk);
    while (irq !== 1'b1) begin
      @(negedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask

  // external master, mode 0, sck period 16 pclk
  task automatic ext(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      emosi <= b[7-k];
      repeat (8) @(posedge pclk);
      esck <= 1;
      m = {m[6:0], pin.miso};
      repeat (8) @(posedge pclk);
      esck <= 0;
    end
  endtask

  function automatic logic [7:0] exp8(input logic [7:0] b, input logic r);
    for (int i = 0; i < 8; i++) exp8[i] = r ? b[7-i] : b[i];
  endfunction

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ack, esck, emosi} = '0;
    {gie, ess, presetn} = 3'b110;
    {num_errors, cmp_count, cyc, ne} = '0;
    mode = 2'b00;
    rd = $urandom(80024);
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, smsp_pkg::OFF_CONTROL, 0);
    chk(32'h0000_0000, rd);
    apb(0, smsp_pkg::OFF_PINDIR, 0);
    chk(32'h0000_0010, rd);
    apb(0, 8'h10, 0);
    chk(32'h0000_0001, {31'h0, err});
    chk(32'h0000_0000, rd);
    apb(1, smsp_pkg::OFF_STATUS, 32'h0000_00FF);
    apb(0, smsp_pkg::OFF_STATUS, 0);
    chk(32'h0000_0001, rd);
    apb(1, smsp_pkg::OFF_PINDIR, 32'h0000_000B);
    apb(1, smsp_pkg::OFF_CONTROL, 32'h0000_0010);
    ne = 0;
    apb(1, smsp_pkg::OFF_DATA, 32'h0000_0055);
    repeat (200) @(posedge pclk);
    chk(0, ne);
    for (int i = 0; i < 8; i++) begin
      mode = i[1:0] ^ {1'b0, i[2]};
      o = 1'($urandom);
      tb = 8'($urandom);
      sb = 8'($urandom);
      h = (i[1:0] == 3) ? 64 : (2 << (2 * i[1:0]));
      if (i[2]) h = h / 2;
      ctl = {3'b110, 1'b1, mode, i[1:0]} | {2'b00, o, 5'h00};
      apb(1, smsp_pkg::OFF_STATUS, {31'h0, i[2]});
      apb(1, smsp_pkg::OFF_CONTROL, {24'h0, ctl});
      // let a polarity change settle before counting edges
      repeat (2) @(posedge pclk);
      ne = 0;
      u_far.load(sb);
      chk(mode[1], pin.sck);
      apb(1, smsp_pkg::OFF_DATA, {24'h0, tb});
      wait_irq();
      chk(16, ne);
      chk(15 * h, t1 - t0);
      chk(mode[1], pin.sck);
      chk(exp8(tb, o), got);
      gie <= 0;
      repeat (2) @(posedge pclk);
      chk(0, irq);
      gie <= 1;
      apb(0, smsp_pkg::OFF_CONTROL, 0);
      chk(ctl, rd);
      chk(2'b10, {po.ss_oe, po.ss_o});
      if (i == 7) begin
        ack <= 1;
        @(posedge pclk);
        ack <= 0;
        @(posedge pclk);
        chk(0, irq);
      end else begin
        apb(0, smsp_pkg::OFF_STATUS, 0);
        chk(32'h80 | i[2], rd);
        apb(0, smsp_pkg::OFF_DATA, 0);
        if (h >= 8) chk(exp8(sb, o), rd);
        chk(0, irq);
      end
    end
    u_far.load(8'h00);
    apb(1, smsp_pkg::OFF_DATA, 32'h0000_00A5);
    apb(1, smsp_pkg::OFF_DATA, 32'h0000_005A);
    wait_irq();
    chk(exp8(8'hA5, o), got);
    apb(0, smsp_pkg::OFF_STATUS, 0);
    chk(32'h0000_00C1, rd);
    apb(0, smsp_pkg::OFF_DATA, 0);
    apb(0, smsp_pkg::OFF_STATUS, 0);
    chk(32'h0000_0001, rd);
    apb(1, smsp_pkg::OFF_PINDIR, 32'h0000_0017);
    apb(1, smsp_pkg::OFF_CONTROL, 32'h0000_00D0);
    ess <= 0;
    wait_irq();
    chk(1, irq);
    apb(0, smsp_pkg::OFF_CONTROL, 0);
    chk(32'h0000_00C0, rd);
    chk(3'b001, {po.sck_oe, po.mosi_oe, po.miso_oe});
    apb(0, smsp_pkg::OFF_STATUS, 0);
    apb(1, smsp_pkg::OFF_DATA, 32'h0000_003C);
    chk(0, irq);
    ext(8'hFF, 3);
    ess <= 1;
    repeat (8) @(posedge pclk);
    chk(0, po.miso_oe);
    ext(8'h00, 8);
    chk(0, irq);
    ess <= 0;
    sb = 8'($urandom);
    ext(sb, 8);
    wait_irq();
    chk(8'h3C, m);
    apb(0, smsp_pkg::OFF_STATUS, 0);
    chk(32'h0000_0081, rd);
    apb(0, smsp_pkg::OFF_DATA, 0);
    chk(sb, rd);
    ess <= 1;
    repeat (8) @(posedge pclk);
    apb(1, smsp_pkg::OFF_CONTROL, 32'h0000_00D0);
    apb(0, smsp_pkg::OFF_CONTROL, 0);
    chk(32'h0000_00D0, rd);
    chk(1, po.sck_oe);
    give_verdict();
  end
endmodule // smsp_port_tb
